// File: design/rofm_params.svh
// Offsets, field positions and reset-time constants of the rail override and fault mask bank.
// Assumes it is included by rofm_regs only, the one module of this bank that uses its macros.
// Functional notes
// - With output four bus-controlled open-drain, a level bit of 0 pulls it low and 1 releases it.
// - With outputs three to one bus-controlled push-pull, a level bit of 0 drives low and 1 drives high.
// - In this version the level bits do nothing, outputs follow their power-good trees, levels default 0.
// - Bit 3 at 0 leaves the termination regulator to pins or power-good, at 1 forces it on unless disabled.
// - Bit 2 forces on the factory-selected one of load switch two or linear one, unless disabled.
// - Bit 1 forces load switch one on unless disabled, else pins or power-good control it.
// - Bit 0 forces linear three on unless disabled, else pins or power-good control it.
// - The low mask register holds the step-down, high switch and linear two shutdown masks, a 1 stops that rail's fault shutting down.
// - The high mask register holds shutdown masks for linear one, termination, the load switches and linear three.
// - A disable bit of 0 holds its rail off whatever the pins and the force bit say.
`ifndef ROFM_PARAMS_SVH
`define ROFM_PARAMS_SVH

`define ROFM_OFS_FORCE      8'ha1
`define ROFM_OFS_MASK_LOW   8'ha2
`define ROFM_OFS_MASK_HIGH  8'ha3
`define ROFM_MASK_HIGH_WMSK 8'h7f
`define ROFM_LEVEL_LSB      4
`define ROFM_RAIL_TERM      0
`define ROFM_RAIL_LSW2      1
`define ROFM_RAIL_LIN1      2
`define ROFM_RAIL_LSW1      3
`define ROFM_RAIL_LIN3      4
`define ROFM_NUM_RAILS      5
`define ROFM_NUM_FAULTS     13

`endif

// File: design/rofm_pkg.sv
// Types shared by the rail override and fault mask bank.
// Assumes rofm_params.svh sits in the include path.
`default_nettype none
package rofm_pkg;
    // Override register layout, bit 7 down to bit 0.
    typedef struct packed {
        logic [3:0] output_level;          // Output four down to output one.
        logic       termination_force_on;
        logic       shared_rail_force_on;
        logic       load_switch_one_force_on;
        logic       linear_three_force_on;
    } rofm_force_t;

    // Low fault mask register layout.
    typedef struct packed {
        logic       linear_two_fault_mask;
        logic       high_switch_fault_mask;
        logic [5:0] step_down_fault_mask;  // Step-down six down to one.
    } rofm_mask_low_t;

    // High fault mask register layout.
    typedef struct packed {
        logic       always_zero;
        logic [1:0] reserved_bits;
        logic       linear_one_fault_mask;
        logic       termination_fault_mask;
        logic       load_switch_two_fault_mask;
        logic       load_switch_one_fault_mask;
        logic       linear_three_fault_mask;
    } rofm_mask_high_t;
endpackage
`default_nettype wire

// File: design/rofm_rail_gate.sv
// Combines pin or power-good requests, force-on bits and disable bits into rail enables.
// Assumes all inputs are synchronous to the caller's clock; the result is combinational.
`default_nettype none
module rofm_rail_gate #(
    parameter int N = 5
) (
    input  wire logic [N-1:0] pin_request,
    input  wire logic [N-1:0] force_on,
    input  wire logic [N-1:0] enable_allow,
    output logic      [N-1:0] rail_enable
);
    // A cleared allow bit wins over both the pins and the force bit.
    assign rail_enable = enable_allow & (force_on | pin_request);
endmodule
`default_nettype wire

// File: design/rofm_regs.sv
// Rail force-on, output level and fault shutdown mask registers with their output logic.
// Assumes the serial bus engine presents one-cycle read and write strobes with an 8-bit offset,
// and that the factory configuration inputs are stable while RESETN is low.
`include "rofm_params.svh"
`default_nettype none
module rofm_regs
    import rofm_pkg::*;
#(
    parameter bit LEVEL_BITS_ACTIVE = 1'b0
) (
    input  wire logic                          CLK,
    input  wire logic                          RESETN,
    input  wire logic                          REG_WR,
    input  wire logic                          REG_RD,
    input  wire logic [7:0]                    REG_ADDR,
    input  wire logic [7:0]                    REG_WDATA,
    output logic      [7:0]                    REG_RDATA,
    output logic                               REG_RVALID,
    input  wire rofm_pkg::rofm_force_t         OTP_FORCE,
    input  wire rofm_pkg::rofm_mask_low_t      OTP_MASK_LOW,
    input  wire rofm_pkg::rofm_mask_high_t     OTP_MASK_HIGH,
    input  wire logic                          OTP_SHARED_IS_LINEAR,
    input  wire logic [3:0]                    OTP_OUT_BUS_CTRL,
    input  wire logic [3:0]                    OTP_OUT_PUSH_PULL,
    input  wire logic [`ROFM_NUM_RAILS-1:0]    PIN_REQUEST,
    input  wire logic [3:0]                    DISABLE_N,
    input  wire logic [3:0]                    PG_TREE,
    input  wire logic [`ROFM_NUM_FAULTS-1:0]   POWER_FAULT,
    output logic      [`ROFM_NUM_RAILS-1:0]    RAIL_ENABLE,
    output logic      [`ROFM_NUM_FAULTS-1:0]   FAULT_MASK,
    output logic                               SHUTDOWN_REQ,
    output logic      [3:0]                    GPO_OUT,
    output logic      [3:0]                    GPO_OE
);
    import rofm_pkg::*;

    rofm_force_t                 force_reg;
    rofm_mask_low_t              mask_low_reg;
    rofm_mask_high_t             mask_high_reg;
    logic [`ROFM_NUM_RAILS-1:0]  force_vec;
    logic [`ROFM_NUM_RAILS-1:0]  allow_vec;
    logic [`ROFM_NUM_RAILS-1:0]  rail_next;
    logic [`ROFM_NUM_FAULTS-1:0] mask_next;
    logic [3:0]                  gpo_out_next;
    logic [3:0]                  gpo_oe_next;
    logic [7:0]                  rdata_next;

    // Write decode for one offset; shared by the three register processes.
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    // Override register; the level bits come up at 0 when this version ignores them.
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            force_reg <= OTP_FORCE;
            if (!LEVEL_BITS_ACTIVE)
            begin
                force_reg.output_level <= 4'h0;
            end
        end
        else if (REG_WR && hit(REG_ADDR, `ROFM_OFS_FORCE))
        begin
            force_reg <= rofm_force_t'(REG_WDATA);
        end
    end

    // Low mask register, every bit writable.
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            mask_low_reg <= OTP_MASK_LOW;
        end
        else if (REG_WR && hit(REG_ADDR, `ROFM_OFS_MASK_LOW))
        begin
            mask_low_reg <= rofm_mask_low_t'(REG_WDATA);
        end
    end

    // High mask register; the top bit is held at 0. Reserved bits keep whatever the host writes,
    // so a careless host that breaks the 0 and 1 pattern is visible on read back.
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            mask_high_reg <= rofm_mask_high_t'(OTP_MASK_HIGH & `ROFM_MASK_HIGH_WMSK);
        end
        else if (REG_WR && hit(REG_ADDR, `ROFM_OFS_MASK_HIGH))
        begin
            mask_high_reg <= rofm_mask_high_t'(REG_WDATA & `ROFM_MASK_HIGH_WMSK);
        end
    end

    // Read mux; offsets outside the bank read as zero rather than echoing a neighbour.
    always_comb
    begin
        rdata_next = 8'h00;
        case (REG_ADDR)
            `ROFM_OFS_FORCE:
            begin
                rdata_next = force_reg;
            end
            `ROFM_OFS_MASK_LOW:
            begin
                rdata_next = mask_low_reg;
            end
            `ROFM_OFS_MASK_HIGH:
            begin
                rdata_next = mask_high_reg;
            end
            default:
            begin
                rdata_next = 8'h00;
            end
        endcase
    end

    // Read port answers one cycle after the strobe. The data holds until the next read, so a slow
    // serial engine may shift it out over many cycles without a copy of its own.
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            REG_RDATA  <= 8'h00;
            REG_RVALID <= 1'b0;
        end
        else
        begin
            REG_RVALID <= REG_RD;
            if (REG_RD)
            begin
                REG_RDATA <= rdata_next;
            end
        end
    end

    // Map force and disable bits onto the five rails; the shared bit steers to the factory choice.
    // Both shared rails take one disable bit; the rail not chosen still follows its own pin request.
    always_comb
    begin
        force_vec = '0;
        allow_vec = '0;
        force_vec[`ROFM_RAIL_TERM] = force_reg.termination_force_on;
        force_vec[`ROFM_RAIL_LSW2] = force_reg.shared_rail_force_on & ~OTP_SHARED_IS_LINEAR;
        force_vec[`ROFM_RAIL_LIN1] = force_reg.shared_rail_force_on & OTP_SHARED_IS_LINEAR;
        force_vec[`ROFM_RAIL_LSW1] = force_reg.load_switch_one_force_on;
        force_vec[`ROFM_RAIL_LIN3] = force_reg.linear_three_force_on;
        allow_vec[`ROFM_RAIL_TERM] = DISABLE_N[3];
        allow_vec[`ROFM_RAIL_LSW2] = DISABLE_N[2];
        allow_vec[`ROFM_RAIL_LIN1] = DISABLE_N[2];
        allow_vec[`ROFM_RAIL_LSW1] = DISABLE_N[1];
        allow_vec[`ROFM_RAIL_LIN3] = DISABLE_N[0];
    end

    rofm_rail_gate #(
        .N (`ROFM_NUM_RAILS)
    ) u_gate (
        .pin_request  (PIN_REQUEST),
        .force_on     (force_vec),
        .enable_allow (allow_vec),
        .rail_enable  (rail_next)
    );

    // Fault mask bits in order: high register low five bits above the low register.
    assign mask_next = {mask_high_reg[4:0], mask_low_reg};

    // Output pins: level bits only where the version honours them and the pin is bus controlled.
    always_comb
    begin
        gpo_out_next = '0;
        gpo_oe_next  = '0;
        for (int i = 0; i < 4; i++)
        begin
            if (LEVEL_BITS_ACTIVE && OTP_OUT_BUS_CTRL[i])
            begin
                // Output four has no push-pull option.
                if (OTP_OUT_PUSH_PULL[i] && i != 3)
                begin
                    gpo_out_next[i] = force_reg.output_level[i];
                    gpo_oe_next[i]  = 1'b1;
                end
                else
                begin
                    gpo_oe_next[i] = ~force_reg.output_level[i];
                end
            end
            else if (OTP_OUT_PUSH_PULL[i] && i != 3)
            begin
                gpo_out_next[i] = PG_TREE[i];
                gpo_oe_next[i]  = 1'b1;
            end
            else
            begin
                gpo_oe_next[i] = ~PG_TREE[i];
            end
        end
    end

    // Registered outputs; rails stay off and the pins released while reset is low.
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            RAIL_ENABLE  <= '0;
            FAULT_MASK   <= '0;
            SHUTDOWN_REQ <= 1'b0;
            GPO_OUT      <= 4'h0;
            GPO_OE       <= 4'h0;
        end
        else
        begin
            RAIL_ENABLE  <= rail_next;
            FAULT_MASK   <= mask_next;
            SHUTDOWN_REQ <= |(POWER_FAULT & ~mask_next);
            GPO_OUT      <= gpo_out_next;
            GPO_OE       <= gpo_oe_next;
        end
    end
endmodule
`default_nettype wire

// File: testbench/rofm_regs_properties.sv
// Port checker for the rail override and fault mask bank.
// Assumes binding to rofm_regs; the output four check applies only where the level bits are ignored.
`default_nettype none
module rofm_regs_properties #(
    parameter bit LEVEL_BITS_ACTIVE = 1'b0
) (
    input wire logic        CLK,
    input wire logic        RESETN,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [7:0]  REG_ADDR,
    input wire logic [7:0]  REG_WDATA,
    input wire logic [7:0]  REG_RDATA,
    input wire logic        REG_RVALID,
    input wire logic [3:0]  DISABLE_N,
    input wire logic [3:0]  PG_TREE,
    input wire logic [12:0] POWER_FAULT,
    input wire logic [4:0]  RAIL_ENABLE,
    input wire logic [12:0] FAULT_MASK,
    input wire logic        SHUTDOWN_REQ,
    input wire logic [3:0]  GPO_OUT,
    input wire logic [3:0]  GPO_OE
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // Outputs set on an edge under reset are zero, so relations on past inputs need a live previous edge.
    sequence s_wr(logic [7:0] a);
        REG_WR && REG_ADDR == a;
    endsequence
    sequence s_force;
        s_wr(8'ha1) ##0 REG_WDATA[1] ##1 DISABLE_N[1];
    endsequence
    property p_rvalid; REG_RD |=> REG_RVALID; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read without valid");
    property p_top_bit; REG_RD && REG_ADDR == 8'ha3 |=> !REG_RDATA[7]; endproperty
    a_top_bit: assert property (p_top_bit) else $error("high mask bit 7 read as one");
    property p_mask_low; s_wr(8'ha2) |=> ##1 FAULT_MASK[7:0] == $past(REG_WDATA, 2); endproperty
    a_mask_low: assert property (p_mask_low) else $error("low mask not applied");
    property p_mask_high; s_wr(8'ha3) |=> ##1 FAULT_MASK[12:8] == $past(REG_WDATA[4:0], 2); endproperty
    a_mask_high: assert property (p_mask_high) else $error("high mask not applied");
    property p_shutdown; $past(RESETN) |-> SHUTDOWN_REQ == |($past(POWER_FAULT) & ~FAULT_MASK); endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown not per masked faults");
    property p_rail_off; $past(RESETN) && !$past(DISABLE_N[3]) |-> !RAIL_ENABLE[0]; endproperty
    a_rail_off: assert property (p_rail_off) else $error("disabled rail enabled");
    property p_force; s_force |=> RAIL_ENABLE[3]; endproperty
    a_force: assert property (p_force) else $error("forced switch not on");
    property p_out_four;
        !LEVEL_BITS_ACTIVE && $past(RESETN) |-> GPO_OE[3] == !$past(PG_TREE[3]) && !GPO_OUT[3];
    endproperty
    a_out_four: assert property (p_out_four) else $error("output four not per tree");
endmodule
bind rofm_regs rofm_regs_properties #(.LEVEL_BITS_ACTIVE(LEVEL_BITS_ACTIVE))
    u_rofm_regs_properties (.CLK, .RESETN, .REG_WR, .REG_RD, .REG_ADDR,
    .REG_WDATA, .REG_RDATA, .REG_RVALID, .DISABLE_N, .PG_TREE, .POWER_FAULT, .RAIL_ENABLE, .FAULT_MASK,
    .SHUTDOWN_REQ, .GPO_OUT, .GPO_OE);
`default_nettype wire

// File: testbench/rofm_host_model.sv
// Host controller model issuing single-byte register accesses.
// Assumes the bank answers a read one cycle after its strobe.
`default_nettype none
module rofm_host_model (
    input  wire logic       clk,
    output logic            wr    = 1'b0,
    output logic            rd    = 1'b0,
    output logic      [7:0] addr  = 8'h00,
    output logic      [7:0] wdata = 8'h00,
    input  wire logic [7:0] rdata,
    input  wire logic       rvalid
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle lines are inverted so a design that ignores the strobe sees wrong values.
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    // High mask writes keep the reserved pair at zero then one.
    task automatic write_mask_high(input logic top, input logic [4:0] m);
        write(8'ha3, {top, 2'b01, m});
    endtask
    // A read waits a bounded number of edges for the valid pulse.
    task automatic read(input logic [7:0] a, output logic [7:0] d, output bit ok);
        int n;
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        n = 0;
        ok = 1'b0;
        while (!ok && n < 4)
        begin
            @(posedge clk);
            ok = (rvalid === 1'b1);
            n++;
        end
        d = rdata;
    endtask
endmodule
`default_nettype wire

// File: testbench/rofm_regs_tb_top.sv
// Self-checking bench for the rail override and fault mask bank.
// Assumes one copy with the level bits ignored and a second copy that honours them.
`default_nettype none
module rofm_regs_tb_top import rofm_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rst_n = 1'b0, wr, rd, rvalid, shut, sel = 1'b0;
    logic [7:0] addr, wdata, rdata;
    logic [3:0] dis_n = 4'hf, tree = 4'h0, gpo_out, gpo_oe, gpo_out_lvl, gpo_oe_lvl;
    logic [4:0] pin = 5'h00, rail;
    logic [12:0] fault = 13'h0000, fmask;
    rofm_force_t otp_force = 8'h00;
    rofm_mask_low_t otp_low = 8'h00;
    rofm_mask_high_t otp_high = 8'h00;
    int cmp_count = 0;
    int err_total = 0;
    rofm_regs u_rofm_regs (.CLK(clk), .RESETN(rst_n), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid), .OTP_FORCE(otp_force), .OTP_MASK_LOW(otp_low),
        .OTP_MASK_HIGH(otp_high), .OTP_SHARED_IS_LINEAR(sel), .OTP_OUT_BUS_CTRL(4'h0), .OTP_OUT_PUSH_PULL(4'hd),
        .PIN_REQUEST(pin), .DISABLE_N(dis_n), .PG_TREE(tree), .POWER_FAULT(fault), .RAIL_ENABLE(rail),
        .FAULT_MASK(fmask), .SHUTDOWN_REQ(shut), .GPO_OUT(gpo_out), .GPO_OE(gpo_oe));
    // Second copy honours the level bits: outputs four to two bus controlled, output one on its tree.
    rofm_regs #(.LEVEL_BITS_ACTIVE(1'b1)) u_rofm_regs_lvl (.CLK(clk), .RESETN(rst_n), .REG_WR(wr), .REG_RD(rd),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(), .REG_RVALID(), .OTP_FORCE(otp_force),
        .OTP_MASK_LOW(otp_low), .OTP_MASK_HIGH(otp_high), .OTP_SHARED_IS_LINEAR(sel), .OTP_OUT_BUS_CTRL(4'he),
        .OTP_OUT_PUSH_PULL(4'hd), .PIN_REQUEST(pin), .DISABLE_N(dis_n), .PG_TREE(tree), .POWER_FAULT(fault),
        .RAIL_ENABLE(), .FAULT_MASK(), .SHUTDOWN_REQ(), .GPO_OUT(gpo_out_lvl), .GPO_OE(gpo_oe_lvl));
    rofm_host_model u_rofm_host_model (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata),
        .rdata(rdata), .rvalid(rvalid));
    // The clock runs at 250 MHz.
    initial
    begin
        forever #2 clk = ~clk;
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // A lost read answer ends the run at once.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bit ok;
        u_rofm_host_model.read(a, d, ok);
        if (!ok)
        begin
            err_total++;
            summarize();
        end
        check("rdata", exp, d);
    endtask
    task automatic do_reset(input logic s);
        rst_n <= 1'b0;
        sel <= s;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    // Rail order is term, switch two, linear one, switch one, linear three from bit 0.
    function automatic logic [4:0] exp_rail(logic [3:0] f, logic [3:0] dn, logic [4:0] p, logic s);
        return {dn[0], dn[1], dn[2], dn[2], dn[3]} & ({f[0], f[1], f[2] & s, f[2] & !s, f[3]} | p);
    endfunction
    task automatic t_reset_values();
        otp_force <= 8'hf5;
        otp_low <= 8'h3c;
        otp_high <= 8'hb6;
        do_reset(1'b0);
        rd_chk(8'ha1, 8'h05);
        rd_chk(8'ha2, 8'h3c);
        rd_chk(8'ha3, 8'h36);
    endtask
    // Masks back to back, an unmapped access, then each fault alone.
    task automatic t_masks();
        logic [12:0] m;
        m = 13'h0a55;
        u_rofm_host_model.write(8'ha2, 8'h55);
        u_rofm_host_model.write_mask_high(1'b1, 5'h0a);
        u_rofm_host_model.write(8'ha4, 8'hff);
        rd_chk(8'ha2, 8'h55);
        rd_chk(8'ha3, 8'h2a);
        rd_chk(8'ha4, 8'h00);
        check("fmask", m, fmask);
        for (int i = 0; i < 13; i++)
        begin
            fault <= 13'h0001 << i;
            repeat (3) @(posedge clk);
            check("shutdown", !m[i], shut);
        end
        fault <= 13'h0000;
    endtask
    // Level bits must not reach the plain copy's pins; push-pull pins always drive, bit 3 of push-pull is ignored.
    // The second copy follows both level patterns on its bus-controlled pins.
    task automatic t_outputs();
        logic [3:0] lv;
        for (int t = 0; t < 32; t++)
        begin
            lv = t[4] ? 4'h0 : 4'hf;
            if (t[3:0] == 4'h0)
            begin
                u_rofm_host_model.write(8'ha1, {lv, 4'h0});
            end
            tree <= t[3:0];
            repeat (3) @(posedge clk);
            check("gpo_oe", 4'h5 | (4'ha & ~t[3:0]), gpo_oe);
            check("gpo_out", 4'h5 & t[3:0], gpo_out);
            check("gpo_oe_lvl", {~lv[3], 1'b1, ~lv[1], 1'b1}, gpo_oe_lvl);
            check("gpo_out_lvl", {1'b0, lv[2], 1'b0, t[0]}, gpo_out_lvl);
        end
    endtask
    task automatic t_rails(input logic s);
        do_reset(s);
        for (int k = 0; k < 32; k++)
        begin
            u_rofm_host_model.write(8'ha1, {4'h0, k[3:0]});
            dis_n <= k[4] ? (s ? 4'h5 : 4'ha) : 4'hf;
            pin <= k[4] ? 5'h05 : 5'h00;
            repeat (3) @(posedge clk);
            check("rail", exp_rail(k[3:0], dis_n, pin, s), rail);
        end
    endtask
    initial
    begin
        t_reset_values();
        t_masks();
        t_outputs();
        t_rails(1'b0);
        t_rails(1'b1);
        summarize();
    end
endmodule
`default_nettype wire
